// ### ecl_eeprom_model.sv
// serial eeprom stand-in answering byte fetches from an image array
`timescale 1ns/1ps
module ecl_eeprom_model
  import ecl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // fetch port
  input wire logic imgReq,
  input wire logic [8:0] imgAddr,
  input wire logic [3:0] gapCyc,
  output logic imgAck,
  output ecl_byte_t imgData
);
  // image array, filled by the bench; marker byte at index 0
  ecl_byte_t mem [0:511];
  logic [3:0] waitCnt;

  // idle data line toggles so no stale byte can pass for a fresh one
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      imgAck <= 1'b0;
      imgData <= 8'h00;
      waitCnt <= 4'h1;
    end else if (imgAck) begin
      imgAck <= 1'b0;
      imgData <= ~imgData;
      waitCnt <= gapCyc;
    end else if (waitCnt != 4'h0) begin
      waitCnt <= waitCnt - 4'h1;
      imgData <= ~imgData;
    end else if (imgReq) begin
      imgAck <= 1'b1;
      imgData <= mem[imgAddr];
    end else begin
      imgData <= ~imgData;
    end
  end
endmodule // ecl_eeprom_model

// ### ecl_image_mem.sv
// image copy kept for software readback, registered read port
`timescale 1ns/1ps
module ecl_image_mem
  import ecl_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 34
) (
  // clock
  input wire logic core_clk,
  // write port
  input wire logic wrEn,
  input wire logic [5:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  // read port
  input wire logic [5:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [0:DEPTH-1];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // ecl_image_mem

// ### ecl_lamp_drv.sv
// speed lamp driver with activity blink
`timescale 1ns/1ps
`include "ecl_params.svh"
module ecl_lamp_drv
  import ecl_pkg::*;
#(
  parameter int BLINK_CYC = `ECL_BLINK_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // line state
  input wire logic [1:0] lineSpeed,
  input wire logic activity,
  // configuration
  input wire logic speed_lamp_style,
  input wire logic [1:0] pin_lamp_select,
  // lamps
  output logic speed_lamp_a,
  output logic speed_lamp_b
);
  logic [$clog2(BLINK_CYC+1)-1:0] blinkCnt_r;
  logic phase_r;
  wire styleEff = speed_lamp_style & (&pin_lamp_select);
  wire litA = (lineSpeed == `ECL_SPD_10) || (lineSpeed == `ECL_SPD_1000);
  wire litB = (lineSpeed == `ECL_SPD_100) || (lineSpeed == `ECL_SPD_1000);
  wire blinkEnd = blinkCnt_r == ($bits(blinkCnt_r))'(BLINK_CYC - 1);
  wire showOn = !styleEff || phase_r;

  // phase returns to on when idle so the lamp never sticks dark
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      blinkCnt_r <= '0;
      phase_r <= 1'b1;
    end else if (!activity) begin
      blinkCnt_r <= '0;
      phase_r <= 1'b1;
    end else if (blinkEnd) begin
      blinkCnt_r <= '0;
      phase_r <= !phase_r;
    end else begin
      blinkCnt_r <= blinkCnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      speed_lamp_a <= 1'b0;
      speed_lamp_b <= 1'b0;
    end else begin
      speed_lamp_a <= litA & showOn;
      speed_lamp_b <= litB & showOn;
    end
  end

  lamp_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    lineSpeed == `ECL_SPD_NONE |=> !speed_lamp_a && !speed_lamp_b)
    else $error("lamp lit without link");
  steady_lamp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !activity && lineSpeed == `ECL_SPD_1000 ##1 !activity && lineSpeed == `ECL_SPD_1000
    |=> speed_lamp_a && speed_lamp_b)
    else $error("lamps not steady while idle");
endmodule // ecl_lamp_drv

// ### ecl_loader.sv
// configuration image loader: fetch, check, decode and expose over wishbone
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "ecl_params.svh"
module ecl_loader
  import ecl_pkg::*;
#(
  parameter int BLINK_CYC = `ECL_BLINK_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // byte fetch from the serial eeprom engine
  output logic imgReq,
  output logic [8:0] imgAddr,
  input wire logic imgAck,
  input wire logic [7:0] imgData,
  // usb core settings
  output logic usbReady,
  output logic usbPinSwap,
  output logic [1:0] hsBoost,
  output logic remoteWake,
  output logic selfPowered,
  output logic langIdOffered,
  output logic [15:0] langId,
  output logic [7:0] fsInterval,
  output logic [7:0] hsInterval,
  // ethernet and pin settings
  output logic [47:0] staAddr,
  output logic dupAuto,
  output logic spdAuto,
  output logic [11:0] wakeEn,
  output logic [7:0] pmeFlags,
  output logic [7:0] cfgFlags1,
  // line state pins and lamps
  input wire logic [1:0] lineSpeedPin,
  input wire logic activityPin,
  output logic speed_lamp_a,
  output logic speed_lamp_b
);
  ecl_state_t state_r;
  ecl_state_t state_nxt;
  logic [8:0] idx_r;
  logic bootPend_r;
  logic loadDone_r;
  logic imgValid_r;
  logic [7:0] attr_r;
  logic ack_r;
  logic imgRd_r;
  logic [31:0] dat_r;
  logic [7:0] fld_r [1:`ECL_IDX_LAST];
  logic [7:0] staByte_r [0:`ECL_STA_BYTES-1];
  logic [7:0] memRd;

  // fetch decode
  wire fetchHit = (state_r == ST_FETCH) && imgAck;
  wire attrHit = (state_r == ST_ATTR) && imgAck;
  wire badMark = (idx_r == 9'({`ECL_IDX_MARK})) && (imgData != `ECL_MARK_VAL);
  wire lastByte = idx_r == 9'({`ECL_IDX_LAST});
  wire hsCfgOn = fld_r[`ECL_IDX_HSCFG] != 8'h00;
  wire cfgPresent = hsCfgOn || (fld_r[`ECL_IDX_FSCFG] != 8'h00);
  wire [7:0] cfgOff = hsCfgOn ? fld_r[`ECL_IDX_HSCFG + 1] : fld_r[`ECL_IDX_FSCFG + 1];
  wire [8:0] attrAddr = {cfgOff, 1'b0} + `ECL_CFG_ATTR_OFS;

  // bus decode
  wire busReq = wb_cyc_i && wb_stb_i;
  wire regWr = busReq && wb_we_i && ack_r;
  wire [7:0] wordIdx = wb_adr_i[9:2];
  wire [7:0] descNum = wordIdx - `ECL_WORD_DESC;
  wire [7:0] imgNum = wordIdx - `ECL_WORD_IMG;
  wire descHit = (wordIdx >= `ECL_WORD_DESC) && (descNum < 8'(`ECL_NUM_DESC));
  wire imgHit = (wordIdx >= `ECL_WORD_IMG) && (imgNum < 8'(`ECL_IMG_DEPTH));
  wire reloadReq = regWr && (wb_adr_i == `ECL_REG_CTRL) && wb_sel_i[0] && wb_dat_i[0];
  wire staLoWr = regWr && (wb_adr_i == `ECL_REG_STA_LO);
  wire staHiWr = regWr && (wb_adr_i == `ECL_REG_STA_HI);

  // load sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (bootPend_r) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (imgAck && badMark) begin
          state_nxt = ST_DONE;
        end else if (imgAck && lastByte) begin
          state_nxt = cfgPresent ? ST_ATTR : ST_DONE;
        end
      end
      ST_ATTR: begin
        if (imgAck) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        if (reloadReq) begin
          state_nxt = ST_FETCH;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      bootPend_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      bootPend_r <= 1'b0;
    end
  end

  // address walks 00h..21h then jumps to the descriptor attribute byte
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_r <= 9'h000;
    end else if (state_nxt == ST_FETCH && state_r != ST_FETCH) begin
      idx_r <= 9'h000;
    end else if (fetchHit && lastByte) begin
      idx_r <= attrAddr;
    end else if (fetchHit) begin
      idx_r <= idx_r + 9'h001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      loadDone_r <= 1'b0;
      imgValid_r <= 1'b0;
      attr_r <= 8'h00;
    end else begin
      loadDone_r <= state_nxt == ST_DONE;
      if (state_r == ST_DONE && reloadReq) begin
        imgValid_r <= 1'b0;
      end else if (fetchHit && badMark) begin
        imgValid_r <= 1'b0;
      end else if (fetchHit && lastByte) begin
        imgValid_r <= 1'b1;
      end
      if (attrHit) begin
        attr_r <= imgData;
      end
    end
  end

  // one byte register per image entry 01h..21h; past 21h only the attribute byte is fetched
  for (genvar gi = 1; gi <= `ECL_IDX_LAST; gi++) begin : g_fld
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        fld_r[gi] <= 8'h00;
      end else if (fetchHit && idx_r == 9'(gi)) begin
        fld_r[gi] <= imgData;
      end
    end
  end

  // station address: image load wins over a same-cycle host write
  for (genvar gb = 0; gb < `ECL_STA_BYTES; gb++) begin : g_sta
    wire load = fetchHit && idx_r == 9'(`ECL_IDX_STA + gb);
    wire hostWr = ((gb < 4) ? staLoWr : staHiWr) && wb_sel_i[gb % 4];
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        staByte_r[gb] <= 8'h00;
      end else if (load) begin
        staByte_r[gb] <= imgData;
      end else if (hostWr) begin
        staByte_r[gb] <= wb_dat_i[8*(gb%4) +: 8];
      end
    end
    assign staAddr[8*gb +: 8] = staByte_r[gb];
  end

  // descriptor table view
  logic [31:0] descWord [0:`ECL_NUM_DESC-1];
  logic [8:0] descAddr [0:`ECL_NUM_DESC-1];
  logic [`ECL_NUM_DESC-1:0] descPresent;
  for (genvar gd = 0; gd < `ECL_NUM_DESC; gd++) begin : g_desc
    wire [7:0] len = fld_r[`ECL_IDX_PAIRS + 2*gd];
    assign descAddr[gd] = {fld_r[`ECL_IDX_PAIRS + 2*gd + 1], 1'b0};
    assign descPresent[gd] = len != 8'h00;
    assign descWord[gd] = {14'h0000, descPresent[gd], descAddr[gd], len};
  end

  // decoded settings
  wire [7:0] flags0 = fld_r[`ECL_IDX_FLAGS0];
  assign usbReady = loadDone_r;
  assign langIdOffered = |descPresent[`ECL_NUM_STR-1:0];
  assign langId = {fld_r[`ECL_IDX_LANG + 1], fld_r[`ECL_IDX_LANG]};
  assign fsInterval = fld_r[`ECL_IDX_FSINT];
  assign hsInterval = fld_r[`ECL_IDX_HSINT];
  assign usbPinSwap = flags0[`ECL_F0_SWAP];
  assign hsBoost = flags0[6:5];
  assign dupAuto = flags0[`ECL_F0_DUPLEX];
  assign spdAuto = flags0[`ECL_F0_SPEED];
  assign remoteWake = cfgPresent ? attr_r[`ECL_ATTR_WAKE] : flags0[1];
  assign selfPowered = cfgPresent ? attr_r[`ECL_ATTR_SELF] : flags0[0];
  assign wakeEn = {fld_r[`ECL_IDX_WAKE + 1][3:0], fld_r[`ECL_IDX_WAKE]};
  assign pmeFlags = fld_r[`ECL_IDX_PME];
  assign cfgFlags1 = fld_r[`ECL_IDX_FLAGS1];
  wire [7:0] flags0Eff = {flags0[7:2], remoteWake, selfPowered};

  // image copy for readback
  ecl_image_mem #(.WIDTH(8), .DEPTH(`ECL_IMG_DEPTH)) u_mem (
    .core_clk(core_clk),
    .wrEn(fetchHit),
    .wrAddr(idx_r[5:0]),
    .wrData(imgData),
    .rdAddr(imgNum[5:0]),
    .rdData(memRd)
  );

  // register read selection; unmapped words read zero
  wire [31:0] rdWord =
    (wb_adr_i == `ECL_REG_STATUS) ? {29'h00000000, langIdOffered, imgValid_r, loadDone_r} :
    (wb_adr_i == `ECL_REG_STA_LO) ? staAddr[31:0] :
    (wb_adr_i == `ECL_REG_STA_HI) ? {16'h0000, staAddr[47:32]} :
    (wb_adr_i == `ECL_REG_USB) ? {langId, hsInterval, fsInterval} :
    (wb_adr_i == `ECL_REG_FLAGS) ? {8'h00, cfgFlags1, pmeFlags, flags0Eff} :
    (wb_adr_i == `ECL_REG_WAKE) ? {20'h00000, wakeEn} :
    descHit ? descWord[descNum[3:0]] :
    32'h00000000;

  // every access acked one cycle after it is seen; writes land on the ack edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      imgRd_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= busReq && !ack_r;
      imgRd_r <= imgHit && (wb_adr_i[1:0] == 2'h0);
      dat_r <= rdWord;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = imgRd_r ? {24'h000000, memRd} : dat_r;
  assign imgReq = (state_r == ST_FETCH) || (state_r == ST_ATTR);
  assign imgAddr = idx_r;

  // line state pins: three stages, value taken when last two agree
  logic [2:0] pinS1_r;
  logic [2:0] pinS2_r;
  logic [2:0] pinS3_r;
  logic [2:0] pinVal_r;
  wire [2:0] pinRaw = {activityPin, lineSpeedPin};
  for (genvar gp = 0; gp < 3; gp++) begin : g_sync
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        pinS1_r[gp] <= 1'b0;
        pinS2_r[gp] <= 1'b0;
        pinS3_r[gp] <= 1'b0;
        pinVal_r[gp] <= 1'b0;
      end else begin
        pinS1_r[gp] <= pinRaw[gp];
        pinS2_r[gp] <= pinS1_r[gp];
        pinS3_r[gp] <= pinS2_r[gp];
        if (pinS2_r[gp] == pinS3_r[gp]) begin
          pinVal_r[gp] <= pinS3_r[gp];
        end
      end
    end
  end

  ecl_lamp_drv #(.BLINK_CYC(BLINK_CYC)) u_lamp (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .lineSpeed(pinVal_r[1:0]),
    .activity(pinVal_r[2]),
    .speed_lamp_style(flags0[`ECL_F0_STYLE]),
    .pin_lamp_select(cfgFlags1[3:2]),
    .speed_lamp_a(speed_lamp_a),
    .speed_lamp_b(speed_lamp_b)
  );

  marker_check_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fetchHit && idx_r == 9'h000 && imgData != 8'hA5 |=> state_r == ST_DONE && !imgValid_r)
    else $error("bad marker not rejected");
  sta_byte_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fetchHit && idx_r == 9'h003 |=> staAddr[23:16] == $past(imgData))
    else $error("station byte misplaced");
  word_offset_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fetchHit && idx_r == 9'h017 |=> descAddr[5] == {$past(imgData), 1'b0})
    else $error("offset not doubled");
  absent_desc_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fetchHit && idx_r == 9'h018 && imgData == 8'h00 |=> !descPresent[6])
    else $error("zero length seen as present");
  no_langid_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    loadDone_r && (fld_r[12] | fld_r[14] | fld_r[16] | fld_r[18] | fld_r[20]) == 8'h00 |-> !langIdOffered)
    else $error("language id offered without strings");
  poll_int_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fetchHit && idx_r == 9'h008 |=> hsInterval == $past(imgData) ##1 hsInterval == $past(hsInterval))
    else $error("high speed interval wrong");
  lang_id_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fetchHit && idx_r == 9'h00B |=> langId[15:8] == $past(imgData))
    else $error("language id high byte wrong");
  wake_bits_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    fetchHit && idx_r == 9'h01F |=> {4'h0, wakeEn[11:8]} == ($past(imgData) & 8'h0F))
    else $error("upper wake enables wrong");
  no_user_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    imgReq && state_r == ST_FETCH |-> imgAddr <= 9'h021)
    else $error("fetch beyond image fields");
  cfg_override_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    attrHit |=> state_r == ST_DONE && {1'b0, selfPowered, 6'h00} == ($past(imgData) & 8'h40)
    && {2'h0, remoteWake, 5'h00} == ($past(imgData) & 8'h20))
    else $error("descriptor does not override flags");
  usb_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    state_r != ST_DONE |-> !usbReady)
    else $error("usb ready before load end");
endmodule // ecl_loader

// ### ecl_loader_tb_top.sv
// self-checking bench for the configuration image loader
`timescale 1ns/1ps
module ecl_loader_tb_top import ecl_pkg::*;;
  logic core_clk, arst_n, wbCyc, wbStb, wbWe, wbAck, imgReq, imgAck, usbReady, usbPinSwap;
  logic remoteWake, selfPowered, langIdOffered, dupAuto, spdAuto, activityPin, lampA, lampB;
  logic [9:0] wbAdr;
  logic [3:0] wbSel, gapCyc;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [8:0] imgAddr;
  logic [8:0] lastAddr = 9'h000;
  logic [3:0] selUse = 4'hF;
  ecl_byte_t imgData, fsInterval, hsInterval, pmeFlags, cfgFlags1;
  logic [1:0] hsBoost, lineSpeedPin;
  logic [15:0] langId;
  logic [47:0] staAddr, expSta;
  logic [11:0] wakeEn;
  int badCount = 0;
  int nCompared = 0;
  int cycles = 0;
  ecl_byte_t f0 [4] = '{8'h96, 8'h2D, 8'hDB, 8'h64};
  ecl_byte_t f1 [4] = '{8'h0C, 8'h00, 8'h0C, 8'hEF};

  ecl_loader #(.BLINK_CYC(8)) ecl_loader_i (
    .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .imgReq(imgReq), .imgAddr(imgAddr), .imgAck(imgAck), .imgData(imgData), .usbReady(usbReady),
    .usbPinSwap(usbPinSwap), .hsBoost(hsBoost), .remoteWake(remoteWake), .selfPowered(selfPowered),
    .langIdOffered(langIdOffered), .langId(langId), .fsInterval(fsInterval), .hsInterval(hsInterval),
    .staAddr(staAddr), .dupAuto(dupAuto), .spdAuto(spdAuto), .wakeEn(wakeEn), .pmeFlags(pmeFlags),
    .cfgFlags1(cfgFlags1), .lineSpeedPin(lineSpeedPin), .activityPin(activityPin),
    .speed_lamp_a(lampA), .speed_lamp_b(lampB));

  ecl_eeprom_model ecl_eeprom_model_i (.core_clk(core_clk), .arst_n(arst_n), .imgReq(imgReq),
    .imgAddr(imgAddr), .gapCyc(gapCyc), .imgAck(imgAck), .imgData(imgData));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // fetch monitor and hang guard
  always @(posedge core_clk) begin
    if (imgReq === 1'b1 && imgAck === 1'b1) lastAddr <= imgAddr;
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      results();
    end
  end

  task results();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // classic single cycle; entered just after a rising edge
  task automatic wbx(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    wbSel <= selUse;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    chk("wishbone ack cycles", 2, n);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic put(input int a, input int v);
    ecl_eeprom_model_i.mem[a] = 8'(v);
  endtask

  // k picks strings present (k!=1) and config descriptors present (even k)
  task automatic build(input int k);
    logic str;
    logic cfg;
    str = (k != 1);
    cfg = (k % 2 == 0);
    put(0, 8'hA5);
    for (int i = 1; i < 7; i++) put(i, 16 * k + i);
    put(7, 1 + k);
    put(8, 4 + k);
    put(9, f0[k]);
    put(10, 9 + k);
    put(11, 4);
    for (int i = 0; i < 5; i++) begin
      put(12 + 2 * i, str ? 10 + 2 * i : 0);
      put(13 + 2 * i, 128 + 8 * i);
    end
    for (int j = 0; j < 4; j++) begin
      put(22 + 2 * j, (j % 2 == 1 && !cfg) ? 0 : 18);
      put(23 + 2 * j, 160 + 16 * j);
    end
    for (int i = 14; i < 17; i++) begin
      if (!str) put(320 + i, 0);
      if (!str) put(384 + i, 0);
    end
    put(30, 60 + k);
    put(31, 8'hF9);
    put(32, 112 + k);
    put(33, f1[k]);
    put(34, 8'hEE);
    put(359, 8'hC0);
    put(423, 8'hA0);
  endtask

  task automatic lamps(input logic blink);
    int tog;
    int wrong;
    logic [1:0] prev;
    for (int s = 0; s < 4; s++) begin
      lineSpeedPin <= 2'(s);
      activityPin <= 1'b1;
      repeat (8) @(posedge core_clk);
      tog = 0;
      wrong = 0;
      prev = {lampB, lampA};
      repeat (24) begin
        @(posedge core_clk);
        if ({lampB, lampA} !== prev) tog++;
        if (({lampB, lampA} & ~2'(s)) !== 2'h0) wrong++;
        if ((!blink || s == 0) && {lampB, lampA} !== 2'(s)) wrong++;
        prev = {lampB, lampA};
      end
      chk("lamp misses", 0, wrong);
      chk("lamp blinking", blink && s != 0, tog >= 2);
      activityPin <= 1'b0;
      repeat (12) @(posedge core_clk);
      chk("lamps idle", s, {lampB, lampA});
    end
  endtask

  task automatic loaded(input int k);
    logic str;
    logic cfg;
    ecl_byte_t ln;
    ecl_byte_t of;
    str = (k != 1);
    cfg = (k % 2 == 0);
    while (usbReady !== 1'b1) begin
      @(posedge core_clk);
    end
    chk("usbReady", 1, usbReady);
    chk("last fetch", cfg ? 9'h167 : 9'h021, lastAddr);
    for (int i = 1; i < 7; i++) expSta[8 * (i - 1) +: 8] = 8'(16 * k + i);
    chk("staAddr", expSta, staAddr);
    chk("fsInterval", 1 + k, fsInterval);
    chk("hsInterval", 4 + k, hsInterval);
    chk("langId", {8'h04, 8'(9 + k)}, langId);
    chk("langIdOffered", str, langIdOffered);
    chk("usbPinSwap", f0[k][7], usbPinSwap);
    chk("hsBoost", f0[k][6:5], hsBoost);
    chk("dupAuto", f0[k][4], dupAuto);
    chk("spdAuto", f0[k][3], spdAuto);
    chk("selfPowered", cfg ? 1'b1 : f0[k][0], selfPowered);
    chk("remoteWake", cfg ? 1'b0 : f0[k][1], remoteWake);
    chk("wakeEn", {4'h9, 8'(60 + k)}, wakeEn);
    chk("pmeFlags", 112 + k, pmeFlags);
    chk("cfgFlags1", f1[k], cfgFlags1);
    wbx(1'b0, 10'h000, 32'h0);
    chk("status", {str, 2'h3}, rd[2:0]);
    wbx(1'b0, 10'h100, 32'h0);
    chk("image marker", 32'h000000A5, rd);
    wbx(1'b0, 10'h014, 32'h0);
    chk("flags reg", {8'h00, f1[k], 8'(112 + k), f0[k][7:2], (cfg ? 2'h1 : f0[k][1:0])}, rd);
    for (int i = 0; i < 9; i++) begin
      wbx(1'b0, 10'(32 + 4 * i), 32'h0);
      ln = ecl_eeprom_model_i.mem[12 + 2 * i];
      of = ecl_eeprom_model_i.mem[13 + 2 * i];
      if (ln != 8'h00) chk("desc", {1'b1, of, 1'b0, ln}, rd[17:0]);
      else chk("absent desc", 9'h000, {rd[17], rd[7:0]});
    end
    lamps(f0[k][2] && f1[k][3:2] == 2'h3);
  endtask

  initial begin
    arst_n = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 10'h000;
    wbSel = 4'h0;
    wbDatI = 32'h0;
    gapCyc = 4'h1;
    lineSpeedPin = 2'h0;
    activityPin = 1'b0;
    build(0);
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("fetch before ready", 2'h2, {imgReq, usbReady});
    loaded(0);
    wbx(1'b0, 10'h3FC, 32'h0);
    chk("unmapped read", 0, rd);
    for (int k = 1; k < 4; k++) begin
      build(k);
      gapCyc <= 4'(1 + 2 * k);
      wbx(1'b1, 10'h004, 32'h1);
      chk("usbReady in reload", 0, usbReady);
      loaded(k);
    end
    put(0, 8'h5A);
    wbx(1'b1, 10'h004, 32'h1);
    repeat (40) @(posedge core_clk);
    wbx(1'b0, 10'h000, 32'h0);
    chk("image valid", 0, rd[1]);
    chk("fetch past marker", 9'h000, lastAddr);
    wbx(1'b0, 10'h100, 32'h0);
    chk("bad marker copy", 32'h0000005A, rd);
    chk("staAddr kept", expSta, staAddr);
    wbx(1'b1, 10'h008, 32'h33221100);
    wbx(1'b1, 10'h00C, 32'h00005544);
    chk("host staAddr", 48'h554433221100, staAddr);
    wbx(1'b0, 10'h008, 32'h0);
    chk("sta low readback", 32'h33221100, rd);
    selUse = 4'h1;
    wbx(1'b1, 10'h008, 32'hFFFFFF77);
    chk("partial staAddr", 48'h554433221177, staAddr);
    results();
  end
endmodule // ecl_loader_tb_top

// ### ecl_params.svh
// image layout, register map and timing constants of the config loader
`ifndef ECL_PARAMS_SVH
`define ECL_PARAMS_SVH
`define ECL_IDX_MARK 6'h00
`define ECL_IDX_STA 6'h01
`define ECL_IDX_FSINT 6'h07
`define ECL_IDX_HSINT 6'h08
`define ECL_IDX_FLAGS0 6'h09
`define ECL_IDX_LANG 6'h0A
`define ECL_IDX_PAIRS 6'h0C
`define ECL_IDX_HSCFG 6'h18
`define ECL_IDX_FSCFG 6'h1C
`define ECL_IDX_WAKE 6'h1E
`define ECL_IDX_PME 6'h20
`define ECL_IDX_FLAGS1 6'h21
`define ECL_IDX_LAST 6'h21
`define ECL_IMG_DEPTH 34
`define ECL_MARK_VAL 8'hA5
`define ECL_NUM_DESC 9
`define ECL_NUM_STR 5
`define ECL_STA_BYTES 6
`define ECL_CFG_ATTR_OFS 9'h007
`define ECL_ATTR_SELF 6
`define ECL_ATTR_WAKE 5
`define ECL_F0_SWAP 7
`define ECL_F0_DUPLEX 4
`define ECL_F0_SPEED 3
`define ECL_F0_STYLE 2
`define ECL_SPD_NONE 2'h0
`define ECL_SPD_10 2'h1
`define ECL_SPD_100 2'h2
`define ECL_SPD_1000 2'h3
`define ECL_REG_STATUS 10'h000
`define ECL_REG_CTRL 10'h004
`define ECL_REG_STA_LO 10'h008
`define ECL_REG_STA_HI 10'h00C
`define ECL_REG_USB 10'h010
`define ECL_REG_FLAGS 10'h014
`define ECL_REG_WAKE 10'h018
`define ECL_WORD_DESC 8'h08
`define ECL_WORD_IMG 8'h40
`define ECL_CLK_KHZ 100000
`define ECL_BLINK_MS 80
`define ECL_BLINK_CYC (`ECL_BLINK_MS * `ECL_CLK_KHZ)
`endif

// ### ecl_pkg.sv
// types shared by the config loader files
package ecl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_ATTR, ST_DONE} ecl_state_t;
  typedef logic [7:0] ecl_byte_t;
endpackage
